// ==== design/uef_flags.sv ====
// serial port with receive-error and transmit-end status flags, APB slave
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "uef_defs.svh"
module uef_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  uef_pkg::uef_ctrl_s ctrl_q;
  uef_pkg::uef_tx_e tx_st_q;
  uef_pkg::uef_rx_e rx_st_q;
  uef_pkg::uef_rxent_s rx_rdata;
  uef_pkg::uef_rxent_s rx_wdata;
  logic [15:0] div_q;
  logic rx_fault_flag_q;
  logic transmit_end_flag_q;
  logic er_arm_q;
  logic transmit_end_flag_arm_q;
  logic tx_wr_q;
  logic [`UEF_IEV_W-1:0] ist_q;
  logic [`UEF_IEV_W-1:0] imsk_q;
  logic rd_wait_q;
  logic [31:0] prdata_q;
  logic [3:0] tx_wp_q;
  logic [3:0] tx_rp_q;
  logic [3:0] rx_wp_q;
  logic [3:0] rx_rp_q;
  logic [4:0] tx_cnt_q;
  logic [4:0] rx_cnt_q;
  logic tx_ne_q;
  logic rx_ne_q;
  logic [3:0] fe_cnt_q;
  logic [3:0] pe_cnt_q;
  logic [7:0] tx_rdata;
  logic [7:0] tx_sh_q;
  logic [2:0] tx_bit_q;
  logic [15:0] tx_bc_q;
  logic tx_par_q;
  logic tx_stop2_q;
  logic txd_q;
  logic [7:0] rx_sh_q;
  logic [2:0] rx_bit_q;
  logic [15:0] rx_bc_q;
  logic rx_par_q;
  logic rx_skip_q;

  //////////////////////////////////////////////////////////////////////
  // bus decode
  wire acc = psel & penable;
  wire rd_first = acc & ~pwrite & ~rd_wait_q;
  wire done = acc & pready;
  wire wr = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire hit_st = paddr == `UEF_OFF_STATUS;
  wire hit_ct = paddr == `UEF_OFF_CTRL;
  wire hit_tx = paddr == `UEF_OFF_TXDATA;
  wire hit_rx = paddr == `UEF_OFF_RXDATA;
  wire hit_dv = paddr == `UEF_OFF_DIV;
  wire hit_is = paddr == `UEF_OFF_IST;
  wire hit_im = paddr == `UEF_OFF_IMSK;
  wire hit_any = hit_st | hit_ct | hit_tx | hit_rx | hit_dv | hit_is | hit_im;
  wire st_wr = wr & hit_st;
  wire ct_wr = wr & hit_ct;

  // reads take two access cycles so fifo read data has settled
  assign pready = pwrite | rd_wait_q;
  assign pslverr = done & ~hit_any;
  assign prdata = prdata_q;

  //////////////////////////////////////////////////////////////////////
  // fifo control
  wire [15:0] div_m1 = div_q - 16'h0001;
  wire tx_busy = tx_st_q != uef_pkg::TX_IDLE;
  wire tx_tick = tx_bc_q == 16'h0000;
  wire rx_tick = rx_bc_q == 16'h0000;
  wire tx_go = ~tx_busy & ctrl_q.tx_enable_bit & tx_ne_q & (tx_cnt_q != 5'h00);
  wire tx_push = wr & hit_tx & (tx_cnt_q != `UEF_FIFO_FULL);
  wire tx_done = (tx_st_q == uef_pkg::TX_STOP) & tx_tick & ~tx_stop2_q;
  wire rx_push = (rx_st_q == uef_pkg::RX_STOP) & rx_tick & ~rx_skip_q;
  wire rx_full = rx_cnt_q == `UEF_FIFO_FULL;
  // full fifo drops the character; overrun is not reported here
  wire rx_push_ok = rx_push & ~rx_full;
  wire rx_pop = rd_done & hit_rx & prdata_q[`UEF_RX_VALID];
  wire rx_fe = ~rxd;
  wire rx_pe = ctrl_q.parity_en & ((^rx_sh_q ^ rx_par_q) != ctrl_q.parity_odd_select);

  assign rx_wdata.pe = rx_pe;
  assign rx_wdata.fe = rx_fe;
  assign rx_wdata.data = rx_sh_q;

  uef_mem #(.W(8)) u_txm (
    .pclk(pclk),
    .we(tx_push),
    .waddr(tx_wp_q),
    .wdata(pwdata[7:0]),
    .raddr(tx_rp_q),
    .rdata(tx_rdata)
  );

  // faulty characters are stored like good ones
  uef_mem #(.W(10)) u_rxm (
    .pclk(pclk),
    .we(rx_push_ok),
    .waddr(rx_wp_q),
    .wdata(rx_wdata),
    .raddr(rx_rp_q),
    .rdata(rx_rdata)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      tx_cnt_q <= 5'h00;
      tx_ne_q <= 1'b0;
    end else begin
      tx_wp_q <= tx_wp_q + {3'h0, tx_push};
      tx_rp_q <= tx_rp_q + {3'h0, tx_go};
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_go};
      tx_ne_q <= tx_cnt_q != 5'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      rx_cnt_q <= 5'h00;
      rx_ne_q <= 1'b0;
    end else begin
      rx_wp_q <= rx_wp_q + {3'h0, rx_push_ok};
      rx_rp_q <= rx_rp_q + {3'h0, rx_pop};
      rx_cnt_q <= rx_cnt_q + {4'h0, rx_push_ok} - {4'h0, rx_pop};
      rx_ne_q <= rx_cnt_q != 5'h00;
    end
  end

  // counts follow the fault bits of stored entries
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fe_cnt_q <= 4'h0;
      pe_cnt_q <= 4'h0;
    end else begin
      fe_cnt_q <= fe_cnt_q + {3'h0, rx_push_ok & rx_fe} - {3'h0, rx_pop & rx_rdata.fe};
      pe_cnt_q <= pe_cnt_q + {3'h0, rx_push_ok & rx_pe} - {3'h0, rx_pop & rx_rdata.pe};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status flags
  // hidden while a character is on the line
  wire transmit_end_flag_vis = transmit_end_flag_q & ~tx_busy;
  wire tx_last = tx_done & (tx_cnt_q == 5'h00);
  wire er_set = rx_push & (rx_fe | rx_pe);
  wire transmit_end_flag_set = tx_last | (ct_wr & ~pwdata[`UEF_CT_TE]);
  // clear needs a prior read of one
  wire er_clr = st_wr & ~pwdata[`UEF_ST_ER] & er_arm_q;
  wire transmit_end_flag_clr = st_wr & ~pwdata[`UEF_ST_TRANSMIT_END_FLAG] & transmit_end_flag_arm_q & tx_wr_q;
  wire [`UEF_IEV_W-1:0] iev = {rx_push_ok, transmit_end_flag_set, er_set};

  // set on fault; reset value; written ones ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fault_flag_q <= `UEF_ER_RST;
    end else if (er_set) begin
      rx_fault_flag_q <= 1'b1;
    end else if (er_clr) begin
      rx_fault_flag_q <= 1'b0;
    end
  end

  // set on last bit out; reset value; enable cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transmit_end_flag_q <= `UEF_TRANSMIT_END_FLAG_RST;
    end else if (transmit_end_flag_set) begin
      transmit_end_flag_q <= 1'b1;
    end else if (transmit_end_flag_clr) begin
      transmit_end_flag_q <= 1'b0;
    end
  end

  // a new set cancels the read, so it cannot be cleared blind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      er_arm_q <= 1'b0;
      transmit_end_flag_arm_q <= 1'b0;
    end else begin
      er_arm_q <= ~er_set & ~st_wr & (er_arm_q | (rd_done & hit_st & prdata_q[`UEF_ST_ER]));
      transmit_end_flag_arm_q <= ~transmit_end_flag_set & ~st_wr & (transmit_end_flag_arm_q | (rd_done & hit_st & prdata_q[`UEF_ST_TRANSMIT_END_FLAG]));
    end
  end

  // data loaded since the flag was last set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wr_q <= 1'b0;
    end else if (tx_push) begin
      tx_wr_q <= 1'b1;
    end else if (transmit_end_flag_set) begin
      tx_wr_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers and read path
  wire [31:0] st_val = {16'h0000, pe_cnt_q, fe_cnt_q, rx_fault_flag_q, transmit_end_flag_vis, 6'h00};
  wire [9:0] rx_ent = rx_ne_q ? rx_rdata : 10'h000;
  wire [31:0] rx_val = {rx_ne_q, 10'h000, rx_cnt_q, 6'h00, rx_ent};
  wire [31:0] rd_mux = hit_st ? st_val :
                       hit_ct ? {27'h0000000, ctrl_q} :
                       hit_tx ? {27'h0000000, tx_cnt_q} :
                       hit_rx ? rx_val :
                       hit_dv ? {16'h0000, div_q} :
                       hit_is ? {29'h00000000, ist_q} :
                       hit_im ? {29'h00000000, imsk_q} : 32'h00000000;
  wire [`UEF_IEV_W-1:0] ist_w1c = (wr & hit_is) ? pwdata[`UEF_IEV_W-1:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      rd_wait_q <= rd_first;
      if (rd_first) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // control writes never touch the fault flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `UEF_CTRL_RST;
      div_q <= `UEF_DIV_RST;
      imsk_q <= 3'h0;
    end else begin
      if (ct_wr) begin
        ctrl_q <= pwdata[4:0];
      end
      if (wr & hit_dv) begin
        div_q <= pwdata[15:0];
      end
      if (wr & hit_im) begin
        imsk_q <= pwdata[`UEF_IEV_W-1:0];
      end
    end
  end

  // new events win over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 3'h0;
    end else begin
      ist_q <= (ist_q & ~ist_w1c) | iev;
    end
  end

  assign irq = |(ist_q & imsk_q);

  //////////////////////////////////////////////////////////////////////
  // transmitter; a disable lets the current character finish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= uef_pkg::TX_IDLE;
      tx_sh_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_bc_q <= 16'h0000;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
      txd_q <= 1'b1;
    end else begin
      tx_bc_q <= tx_tick ? div_m1 : tx_bc_q - 16'h0001;
      unique case (tx_st_q)
        uef_pkg::TX_IDLE: begin
          tx_bc_q <= div_m1;
          if (tx_go) begin
            tx_st_q <= uef_pkg::TX_START;
            tx_sh_q <= tx_rdata;
            tx_par_q <= ^tx_rdata ^ ctrl_q.parity_odd_select;
            txd_q <= 1'b0;
          end
        end
        uef_pkg::TX_START: begin
          if (tx_tick) begin
            tx_st_q <= uef_pkg::TX_DATA;
            tx_bit_q <= 3'h0;
            txd_q <= tx_sh_q[0];
          end
        end
        uef_pkg::TX_DATA: begin
          if (tx_tick) begin
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'h1;
            txd_q <= tx_sh_q[1];
            if (tx_bit_q == 3'h7) begin
              tx_st_q <= ctrl_q.parity_en ? uef_pkg::TX_PAR : uef_pkg::TX_STOP;
              txd_q <= ctrl_q.parity_en ? tx_par_q : 1'b1;
              tx_stop2_q <= ctrl_q.two_stop;
            end
          end
        end
        uef_pkg::TX_PAR: begin
          if (tx_tick) begin
            tx_st_q <= uef_pkg::TX_STOP;
            txd_q <= 1'b1;
          end
        end
        uef_pkg::TX_STOP: begin
          if (tx_tick) begin
            tx_stop2_q <= 1'b0;
            if (!tx_stop2_q) begin
              tx_st_q <= uef_pkg::TX_IDLE;
            end
          end
        end
        default: begin
          tx_st_q <= uef_pkg::TX_IDLE;
        end
      endcase
    end
  end

  assign txd = txd_q;

  //////////////////////////////////////////////////////////////////////
  // receiver; samples mid-bit and never stalls on a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= uef_pkg::RX_IDLE;
      rx_sh_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_bc_q <= 16'h0000;
      rx_par_q <= 1'b0;
      rx_skip_q <= 1'b0;
    end else if (!ctrl_q.rx_enable_bit) begin
      rx_st_q <= uef_pkg::RX_IDLE;
      rx_skip_q <= 1'b0;
    end else begin
      rx_bc_q <= rx_tick ? div_m1 : rx_bc_q - 16'h0001;
      unique case (rx_st_q)
        uef_pkg::RX_IDLE: begin
          rx_bc_q <= {1'b0, div_q[15:1]};
          if (!rxd) begin
            rx_st_q <= uef_pkg::RX_START;
          end
        end
        uef_pkg::RX_START: begin
          if (rx_tick) begin
            rx_st_q <= rxd ? uef_pkg::RX_IDLE : uef_pkg::RX_DATA;
            rx_bit_q <= 3'h0;
          end
        end
        uef_pkg::RX_DATA: begin
          if (rx_tick) begin
            rx_sh_q <= {rxd, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= ctrl_q.parity_en ? uef_pkg::RX_PAR : uef_pkg::RX_STOP;
            end
          end
        end
        uef_pkg::RX_PAR: begin
          if (rx_tick) begin
            rx_par_q <= rxd;
            rx_st_q <= uef_pkg::RX_STOP;
          end
        end
        // judge the first stop bit only; a low second one must not look like a start
        uef_pkg::RX_STOP: begin
          if (rx_tick) begin
            if (ctrl_q.two_stop && !rx_skip_q) begin
              rx_skip_q <= 1'b1;
              rx_bc_q <= div_m1 + {1'b0, div_q[15:1]};
            end else begin
              rx_skip_q <= 1'b0;
              rx_st_q <= uef_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          rx_st_q <= uef_pkg::RX_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_frame_bad;
    rx_push && rx_fe;
  endsequence

  sequence s_parity_bad;
    rx_push && rx_pe && !rx_fe;
  endsequence

  sequence s_last_out;
    tx_done && tx_cnt_q == 5'h00;
  endsequence

  sequence s_er_read_write;
    er_arm_q && st_wr && !pwdata[`UEF_ST_ER];
  endsequence

  chk_stop_sets_fault: assert property (s_frame_bad |=> rx_fault_flag_q)
    else $error("low stop bit did not raise fault flag");
  chk_first_stop_only: assert property (rx_push |=> rx_st_q == uef_pkg::RX_IDLE || rx_skip_q)
    else $error("receiver waited past the first stop bit");
  chk_parity_sets_fault: assert property (s_parity_bad |=> rx_fault_flag_q && ist_q[0])
    else $error("parity fault did not raise fault flag");
  chk_er_read_first: assert property ($fell(rx_fault_flag_q) |-> $past(er_arm_q && st_wr))
    else $error("fault flag cleared without read then write");
  chk_er_clear_works: assert property (s_er_read_write ##0 !er_set |=> !rx_fault_flag_q)
    else $error("read then write zero failed to clear fault flag");
  chk_re_keeps_er: assert property ($fell(ctrl_q.rx_enable_bit) && !$past(rx_push)
    |-> rx_fault_flag_q == $past(rx_fault_flag_q))
    else $error("receiver disable changed fault flag");
  chk_bad_char_kept: assert property (rx_push && (rx_fe || rx_pe) && rx_cnt_q == 5'h00 && !rx_pop
    |=> rx_cnt_q == 5'h01 ##2 rx_ne_q)
    else $error("faulty character not stored");
  chk_frame_count: assert property (rx_push_ok && rx_fe && !rx_pop
    |=> fe_cnt_q == $past(fe_cnt_q) + 4'h1)
    else $error("framing count did not follow stored entry");
  chk_end_on_idle: assert property (s_last_out |=> transmit_end_flag_q && !tx_busy)
    else $error("end flag not set after last bit");
  chk_te_sets_end: assert property (ct_wr && !pwdata[`UEF_CT_TE] |=> transmit_end_flag_q)
    else $error("clearing transmit enable did not set end flag");
  chk_end_clear_cond: assert property ($fell(transmit_end_flag_q)
    |-> $past(transmit_end_flag_arm_q && tx_wr_q && st_wr))
    else $error("end flag cleared without load, read and write");
  chk_end_hidden_busy: assert property (tx_busy |-> !st_val[`UEF_ST_TRANSMIT_END_FLAG])
    else $error("end flag visible during transmission");
  chk_write_no_set: assert property (st_wr && !rx_fault_flag_q && !er_set |=> !rx_fault_flag_q)
    else $error("status write set the fault flag");
  chk_set_cancels_read: assert property (er_set |=> !er_arm_q)
    else $error("read survived a new fault");
endmodule

// ==== design/uef_defs.svh ====
// register map, field positions, reset values and rule overview of the status flag block
// Overview of operation
// - stop bit low at end sets fault
// - two stop bits: check first only
// - parity mismatch sets fault flag
// - fault flag cleared by read-one-then-write-zero
// - reset clears fault flag
// - disabling receiver keeps fault flag
// - faulty characters still stored, reception continues
// - per-entry framing and parity counts readable
// - end flag set when last bit leaves, fifo empty
// - reset sets end flag
// - clearing transmit enable sets end flag
// - end flag cleared by load, read, write-zero
// - end flag reads zero while transmitting
// - writing one to flags does nothing
`ifndef UEF_DEFS_SVH
`define UEF_DEFS_SVH
`define UEF_OFF_STATUS 8'h00
`define UEF_OFF_CTRL 8'h04
`define UEF_OFF_TXDATA 8'h08
`define UEF_OFF_RXDATA 8'h0c
`define UEF_OFF_DIV 8'h10
`define UEF_OFF_IST 8'h14
`define UEF_OFF_IMSK 8'h18
`define UEF_ST_ER 7
`define UEF_ST_TRANSMIT_END_FLAG 6
`define UEF_CT_TE 1
`define UEF_RX_VALID 31
`define UEF_IEV_W 3
`define UEF_FIFO_FULL 5'h10
`define UEF_ER_RST 1'b0
`define UEF_TRANSMIT_END_FLAG_RST 1'b1
`define UEF_CTRL_RST 5'h00
`define UEF_DIV_RST 16'h00ad
`endif

// ==== design/uef_pkg.sv ====
// types shared by the status flag block
package uef_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uef_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uef_rx_e;
  typedef struct packed {
    logic two_stop;
    logic parity_odd_select;
    logic parity_en;
    logic tx_enable_bit;
    logic rx_enable_bit;
  } uef_ctrl_s;
  typedef struct packed {
    logic pe;
    logic fe;
    logic [7:0] data;
  } uef_rxent_s;
endpackage

// ==== design/uef_mem.sv ====
// sixteen-entry storage with registered read data
`timescale 1ns/10ps
module uef_mem #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [3:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [16];

  // no reset: contents are only read behind a valid count
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ==== testbench/uef_peer.sv ====
// remote serial peer: drives frames onto rxd and captures frames from txd
`timescale 1ns/10ps
module uef_peer #(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // one frame, lsb first; pbad flips parity, s1/s2 give the stop levels
  task automatic send(input logic [7:0] d, input logic pen, input logic odd, input logic pbad,
                      input logic s1, input logic s2, input logic two);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < 8; i++) q.push_back(d[i]);
    if (pen) q.push_back(^d ^ odd ^ pbad);
    q.push_back(s1);
    if (two) q.push_back(s2);
    foreach (q[i]) begin
      @(posedge pclk);
      rxd <= q[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    // line idles high between frames, a full bit of gap
    @(posedge pclk);
    rxd <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // bounded wait for a start bit, then sample mid-bit
  task automatic recv(output logic [7:0] d);
    int n;
    n = 0;
    d = 8'h00;
    while (txd === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge pclk);
      d[i] = txd;
    end
    repeat (BIT_CYC) @(posedge pclk);
  endtask
endmodule

// ==== testbench/uef_flags_tb_top.sv ====
// self-checking bench for the serial status flag block
`timescale 1ns/10ps
`include "uef_defs.svh"
module uef_flags_tb_top;
  localparam int DIV = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, rxd, txd, irq, err;
  logic [7:0] got;
  int fail_count = 0;
  int total_checks = 0;
  always #25 pclk = ~pclk;
  uef_flags i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .irq(irq));
  uef_peer #(.BIT_CYC(DIV)) i_peer (.pclk(pclk), .txd(txd), .rxd(rxd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle edge first so psel is never assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[15:0]), 32'h40);
    check(32'(irq), 32'h0);
    rd(8'h1c);
    check({rdv[30:0], err}, 32'h1);
  endtask
  task automatic t_tx();
    wr(`UEF_OFF_DIV, DIV);
    wr(`UEF_OFF_CTRL, 32'h3);
    fork
      i_peer.recv(got);
      begin
        wr(`UEF_OFF_TXDATA, 32'ha5);
        repeat (4) @(posedge pclk);
        rd(`UEF_OFF_STATUS);
        check(32'(rdv[6]), 32'h0);
      end
    join
    check(32'(got), 32'ha5);
    repeat (16) @(posedge pclk);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[7:6]), 32'h1);
  endtask
  task automatic t_transmit_end_flag();
    wr(`UEF_OFF_CTRL, 32'h1);
    wr(`UEF_OFF_STATUS, 32'hff);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[7:6]), 32'h1);
    wr(`UEF_OFF_STATUS, 32'h0);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[6]), 32'h1);
    // no load since the flag was set, so a read then a zero write must not clear it
    wr(`UEF_OFF_STATUS, 32'h0);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[6]), 32'h1);
    wr(`UEF_OFF_TXDATA, 32'h3c);
    rd(`UEF_OFF_STATUS);
    wr(`UEF_OFF_STATUS, 32'h0);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[6]), 32'h0);
    wr(`UEF_OFF_CTRL, 32'h1);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[6]), 32'h1);
    fork
      i_peer.recv(got);
      wr(`UEF_OFF_CTRL, 32'h3);
    join
    check(32'(got), 32'h3c);
  endtask
  task automatic t_rx_frame();
    i_peer.send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(`UEF_OFF_STATUS, 32'h0);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[15:7]), 32'h3);
    wr(`UEF_OFF_CTRL, 32'h2);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[7]), 32'h1);
    wr(`UEF_OFF_CTRL, 32'h3);
    i_peer.send(8'hc3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    rd(`UEF_OFF_RXDATA);
    check(32'({rdv[31], rdv[9:0]}), 32'h55a);
    rd(`UEF_OFF_RXDATA);
    check(32'({rdv[31], rdv[9:0]}), 32'h4c3);
    rd(`UEF_OFF_STATUS);
    wr(`UEF_OFF_STATUS, 32'h0);
    rd(`UEF_OFF_STATUS);
    check(32'(rdv[7]), 32'h0);
  endtask
  task automatic t_rx_par();
    for (int o = 0; o < 2; o++) begin
      wr(`UEF_OFF_CTRL, {27'h0, 1'b1, o[0], 3'b111});
      i_peer.send(8'h96, 1'b1, o[0], 1'b0, 1'b1, 1'b0, 1'b1);
      rd(`UEF_OFF_STATUS);
      check(32'(rdv[7]), 32'h0);
      i_peer.send(8'h96, 1'b1, o[0], 1'b1, 1'b1, 1'b1, 1'b1);
      rd(`UEF_OFF_RXDATA);
      check(32'({rdv[31], rdv[9:0]}), 32'h496);
      rd(`UEF_OFF_RXDATA);
      check(32'({rdv[31], rdv[9:0]}), 32'h696);
      rd(`UEF_OFF_STATUS);
      i_peer.send(8'h96, 1'b1, o[0], 1'b1, 1'b1, 1'b1, 1'b1);
      wr(`UEF_OFF_STATUS, 32'h0);
      rd(`UEF_OFF_STATUS);
      check(32'(rdv[7]), 32'h1);
      wr(`UEF_OFF_STATUS, 32'h0);
      rd(`UEF_OFF_RXDATA);
    end
  endtask
  task automatic t_irq();
    wr(`UEF_OFF_IST, 32'h7);
    wr(`UEF_OFF_IMSK, 32'h1);
    rd(`UEF_OFF_IST);
    check({rdv[2:0], irq}, 4'h0);
    i_peer.send(8'h11, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    check(32'(irq), 32'h1);
    wr(`UEF_OFF_IMSK, 32'h0);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    wr(`UEF_OFF_IMSK, 32'h1);
    wr(`UEF_OFF_IST, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    rd(`UEF_OFF_RXDATA);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tx();
    t_transmit_end_flag();
    t_rx_frame();
    t_rx_par();
    t_irq();
    conclude();
  end
  // the whole sequence needs well under a third of this
  initial begin
    repeat (40000) @(posedge pclk);
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    conclude();
  end
endmodule
